// File: hw/interlock_pkg.sv
// Overview of operation
// - bypass jumper fitted: charge pump counts as always valid for output gating, outputs enabled
// - watchdog active: spindle and coolant relays and step pulses pass only with a valid charge pump
// - shared PWM mode: PWM line 1, reduction line 17, watchdog line 16
// - no-watchdog mode: relay line 1, PWM line 17, reduction line 16, bypass needed
// - no-reduction mode: relay line 1, PWM line 17, watchdog line 16
// - no-PWM mode: relay line 1, reduction line 17, watchdog line 16, PWM ignored
// - shared line: spindle relay on while measured PWM duty is at least ten percent
// - open emergency-stop loop forces spindle and coolant relays off
// - emergency stop lights its indicator and pulls host status line low
// - any drive fault lights the fault indicator and pulls host status low
// - brake relay energized only when no emergency stop and no drive fault
// - speed output proportional to PWM duty, zero to full scale
// - external driver status line: high means fault
package interlock_pkg;
    typedef enum logic [1:0] {
        CFG_SHARED = 2'b00,
        CFG_NO_WDOG = 2'b01,
        CFG_NO_CRED = 2'b11,
        CFG_NO_PWM = 2'b10
    } line_cfg_e;

    localparam int CLK_HZ = 125_000_000;
    localparam int CP_MIN_HZ = 5_000;
    // a square wave toggles twice per period, so allow one full period between edges
    localparam int CP_TIMEOUT_CYC = CLK_HZ / CP_MIN_HZ;
    localparam int CP_CNT_W = 16;
    localparam logic [3:0] CP_GOOD_EDGES = 4'h8;
    localparam int PWM_MIN_HZ = 45;
    localparam int PWM_TIMEOUT_CYC = CLK_HZ / PWM_MIN_HZ;
    localparam int PWM_CNT_W = 22;
    localparam int SPEED_W = 10;
    localparam int RELAY_PCT = 10;
    localparam int FULL_PCT = 100;

    // apb register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN = 8'h10;
    localparam logic [7:0] REG_SPEED = 8'h14;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam int IRQ_ESTOP = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_CPLOST = 2;
    localparam int IRQ_CPOK = 3;
endpackage

// File: hw/pwm_duty_meter.sv
`timescale 1ns/1ps
module pwm_duty_meter (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset, active high
    input wire logic pwmIn, // pwm input
    output logic [interlock_pkg::SPEED_W-1:0] speed, // duty, full scale at 100 %
    output logic dutyTen // duty at least ten percent
);
    typedef struct packed {
        logic pwmPrev;
        logic [interlock_pkg::PWM_CNT_W-1:0] periodCnt;
        logic [interlock_pkg::PWM_CNT_W-1:0] highCnt;
        logic [interlock_pkg::PWM_CNT_W-1:0] idleCnt;
        logic [interlock_pkg::SPEED_W-1:0] speed;
        logic dutyTen;
    } meter_s;

    meter_s st_r, st_nxt;
    logic [interlock_pkg::PWM_CNT_W+interlock_pkg::SPEED_W-1:0] scaled;
    logic [interlock_pkg::PWM_CNT_W+6:0] highPct;
    logic [interlock_pkg::PWM_CNT_W+6:0] periodPct;

    // duty is measured over a full period, rising edge to rising edge
    always_comb begin
        st_nxt = st_r;
        scaled = '0;
        highPct = '0;
        periodPct = '0;
        st_nxt.pwmPrev = pwmIn;
        if (pwmIn && !st_r.pwmPrev) begin
            scaled = ({10'h0, st_r.highCnt} << interlock_pkg::SPEED_W)
                - {10'h0, st_r.highCnt};
            if (st_r.periodCnt != '0) begin
                st_nxt.speed = interlock_pkg::SPEED_W'(scaled / {10'h0, st_r.periodCnt});
            end
            highPct = {7'h0, st_r.highCnt} * (interlock_pkg::PWM_CNT_W+7)'(interlock_pkg::FULL_PCT);
            periodPct = {7'h0, st_r.periodCnt} *
                (interlock_pkg::PWM_CNT_W+7)'(interlock_pkg::RELAY_PCT);
            st_nxt.dutyTen = (st_r.periodCnt != '0) && (highPct >= periodPct);
            st_nxt.periodCnt = (interlock_pkg::PWM_CNT_W)'(1);
            st_nxt.highCnt = (interlock_pkg::PWM_CNT_W)'(1);
            st_nxt.idleCnt = '0;
        end else begin
            if (st_r.periodCnt != '1) st_nxt.periodCnt = st_r.periodCnt + 1'b1;
            if (pwmIn && st_r.highCnt != '1) st_nxt.highCnt = st_r.highCnt + 1'b1;
            if (st_r.idleCnt != '1) st_nxt.idleCnt = st_r.idleCnt + 1'b1;
            // a line stuck for longer than the slowest period is 0 % or 100 %
            if (st_r.idleCnt >= (interlock_pkg::PWM_CNT_W)'(interlock_pkg::PWM_TIMEOUT_CYC)) begin
                st_nxt.speed = pwmIn ? '1 : '0;
                st_nxt.dutyTen = pwmIn;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign speed = st_r.speed;
    assign dutyTen = st_r.dutyTen;
endmodule

// File: hw/breakout_interlock.sv
`timescale 1ns/1ps
module breakout_interlock (
    input wire logic clk_sys, // system clock, 125 MHz
    input wire logic rst, // sync reset, active high
    input wire logic line1, // host line 1
    input wire logic line16, // host line 16
    input wire logic line17, // host line 17
    input wire logic line14, // host coolant relay request
    input wire logic [3:0] stepIn, // host step pulses, axes 1..4
    input wire logic [3:0] dirIn, // host direction, axes 1..4
    input wire logic wdogBypass, // bypass jumper fitted
    input wire logic [1:0] lineCfg, // routing jumper selection
    input wire logic estopOpen, // emergency-stop loop open
    input wire logic [2:0] stageFault, // internal power stage faults
    input wire logic axis4Status, // external driver status, high = error
    output logic [3:0] stepOut, // gated step pulses
    output logic [3:0] dirOut, // direction to drives
    output logic currentReduce, // current reduction to drives
    output logic spindleRelay, // relay 1
    output logic coolantRelay, // relay 2
    output logic brakeRelay, // holding brake relay, high = brake open
    output logic hostStatusN, // host status line, low = stop
    output logic ledEstop, // emergency stop indicator
    output logic ledFault, // drive fault indicator
    output logic ledCpump, // charge pump valid indicator
    output logic [interlock_pkg::SPEED_W-1:0] speedOut, // speed value, full scale = 100 %
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic irq // level interrupt
);
    typedef struct packed {
        logic cpPrev;
        logic [interlock_pkg::CP_CNT_W-1:0] cpIdle;
        logic [3:0] cpGood;
        logic cpValid;
        logic swHold;
        logic swCoolOff;
        logic [3:0] irqStat;
        logic [3:0] irqEn;
        logic estopPrev;
        logic faultPrev;
        logic cpValidPrev;
        logic [3:0] stepQ;
        logic [3:0] dirQ;
        logic credQ;
        logic spindleQ;
        logic coolantQ;
        logic brakeQ;
        logic statusNQ;
        logic [31:0] rdata;
    } core_s;

    core_s st_r, st_nxt;
    logic cpLine, pwmLine, relayLine, credLine;
    logic dutyTen, driveFault, enabled, spindleReq;
    logic [3:0] events;
    logic [interlock_pkg::SPEED_W-1:0] speedVal;
    logic apbAccess, apbMapped;

    // line routing per jumper selection
    always_comb begin
        cpLine = line16;
        pwmLine = 1'b0;
        relayLine = line1;
        credLine = 1'b0;
        case (interlock_pkg::line_cfg_e'(lineCfg))
            interlock_pkg::CFG_SHARED: begin
                pwmLine = line1;
                credLine = line17;
                relayLine = 1'b0;
            end
            interlock_pkg::CFG_NO_WDOG: begin
                pwmLine = line17;
                credLine = line16;
                cpLine = 1'b0;
            end
            interlock_pkg::CFG_NO_CRED: begin
                pwmLine = line17;
            end
            interlock_pkg::CFG_NO_PWM: begin
                credLine = line17;
            end
            default: begin
                relayLine = 1'b0;
            end
        endcase
    end

    pwm_duty_meter u_meter (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwmIn(pwmLine),
        .speed(speedVal),
        .dutyTen(dutyTen)
    );

    // spindle request: duty threshold on the shared line, else the relay line
    assign spindleReq = (interlock_pkg::line_cfg_e'(lineCfg) == interlock_pkg::CFG_SHARED)
        ? dutyTen : relayLine;
    assign driveFault = (|stageFault) | axis4Status;
    // no-watchdog mode relies on the bypass jumper; without it step pulses and the spindle and coolant relays stay off
    assign enabled = wdogBypass | st_r.cpValid;
    assign events = {st_r.cpValid & ~st_r.cpValidPrev, ~st_r.cpValid & st_r.cpValidPrev,
        driveFault & ~st_r.faultPrev, estopOpen & ~st_r.estopPrev};

    assign apbAccess = psel & penable;
    assign apbMapped = (paddr == interlock_pkg::REG_CTRL) ||
        (paddr == interlock_pkg::REG_STATUS) || (paddr == interlock_pkg::REG_IRQ_STAT) ||
        (paddr == interlock_pkg::REG_IRQ_CLR) || (paddr == interlock_pkg::REG_IRQ_EN) ||
        (paddr == interlock_pkg::REG_SPEED);

    always_comb begin
        st_nxt = st_r;
        // charge pump watchdog: any edge restarts the timeout
        st_nxt.cpPrev = cpLine;
        if (cpLine != st_r.cpPrev) begin
            st_nxt.cpIdle = '0;
            if (st_r.cpGood != interlock_pkg::CP_GOOD_EDGES) begin
                st_nxt.cpGood = st_r.cpGood + 1'b1;
            end else begin
                st_nxt.cpValid = 1'b1;
            end
        end else if (st_r.cpIdle >=
                (interlock_pkg::CP_CNT_W)'(interlock_pkg::CP_TIMEOUT_CYC)) begin
            st_nxt.cpValid = 1'b0;
            st_nxt.cpGood = '0;
        end else begin
            st_nxt.cpIdle = st_r.cpIdle + 1'b1;
        end

        // outputs registered; safety forcing overrides host commands
        st_nxt.stepQ = enabled ? stepIn : 4'h0;
        st_nxt.dirQ = dirIn;
        st_nxt.credQ = credLine;
        st_nxt.spindleQ = enabled & ~estopOpen & ~st_r.swHold & spindleReq;
        st_nxt.coolantQ = enabled & ~estopOpen & ~st_r.swHold & ~st_r.swCoolOff & line14;
        st_nxt.brakeQ = ~estopOpen & ~driveFault;
        st_nxt.statusNQ = ~(estopOpen | driveFault);

        // sticky events: a new event wins over a clear in the same cycle
        st_nxt.estopPrev = estopOpen;
        st_nxt.faultPrev = driveFault;
        st_nxt.cpValidPrev = st_r.cpValid;
        if (apbAccess && pwrite && paddr == interlock_pkg::REG_IRQ_CLR) begin
            st_nxt.irqStat = st_r.irqStat & ~pwdata[3:0];
        end
        st_nxt.irqStat = st_nxt.irqStat | events;

        if (apbAccess && pwrite && paddr == interlock_pkg::REG_CTRL) begin
            st_nxt.swHold = pwdata[0];
            st_nxt.swCoolOff = pwdata[1];
        end
        if (apbAccess && pwrite && paddr == interlock_pkg::REG_IRQ_EN) begin
            st_nxt.irqEn = pwdata[3:0];
        end

        // read data captured in setup so it stands through the access phase
        st_nxt.rdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                interlock_pkg::REG_CTRL: st_nxt.rdata = {30'h0, st_r.swCoolOff, st_r.swHold};
                interlock_pkg::REG_STATUS: st_nxt.rdata = {23'h0, st_r.spindleQ,
                    st_r.coolantQ, st_r.brakeQ, wdogBypass, lineCfg, st_r.cpValid,
                    driveFault, estopOpen};
                interlock_pkg::REG_IRQ_STAT: st_nxt.rdata = {28'h0, st_r.irqStat};
                interlock_pkg::REG_IRQ_EN: st_nxt.rdata = {28'h0, st_r.irqEn};
                interlock_pkg::REG_SPEED: st_nxt.rdata = {22'h0, speedVal};
                default: st_nxt.rdata = 32'h0;
            endcase
        end else if (psel && penable) begin
            st_nxt.rdata = st_r.rdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
            st_r.irqEn <= interlock_pkg::IRQ_EN_RST;
            st_r.statusNQ <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stepOut = st_r.stepQ;
    assign dirOut = st_r.dirQ;
    assign currentReduce = st_r.credQ;
    assign spindleRelay = st_r.spindleQ;
    assign coolantRelay = st_r.coolantQ;
    assign brakeRelay = st_r.brakeQ;
    assign hostStatusN = st_r.statusNQ;
    assign ledEstop = st_r.estopPrev;
    assign ledFault = st_r.faultPrev;
    assign ledCpump = st_r.cpValid;
    assign speedOut = speedVal;
    assign prdata = st_r.rdata;
    assign pready = 1'b1; // every access completes in its first access cycle
    assign pslverr = apbAccess & ~apbMapped;
    assign irq = |(st_r.irqStat & st_r.irqEn);
endmodule

// File: testbench/interlock_sva.sv
`timescale 1ns/1ps
module interlock_sva (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic line16, // pump line
    input wire logic wdogBypass, // bypass
    input wire logic [1:0] lineCfg, // routing
    input wire logic estopOpen, // loop open
    input wire logic [2:0] stageFault, // stage faults
    input wire logic axis4Status, // ext fault
    input wire logic [3:0] stepOut, // steps out
    input wire logic currentReduce, // reduction
    input wire logic spindleRelay, // relay 1
    input wire logic coolantRelay, // relay 2
    input wire logic brakeRelay, // brake open
    input wire logic hostStatusN, // host status
    input wire logic ledEstop, // stop led
    input wire logic ledFault, // fault led
    input wire logic ledCpump // pump led
);
    localparam int CP_IDLE_MAX = interlock_pkg::CP_TIMEOUT_CYC + 4;
    logic anyFault;
    logic cpPrev_r;
    logic [15:0] idleCnt_r;
    assign anyFault = (stageFault != 3'h0) || axis4Status;
    // cycles since the pump line moved; saturates so it never wraps
    always_ff @(posedge clk_sys) begin
        cpPrev_r <= line16;
        if (rst || line16 != cpPrev_r) idleCnt_r <= 16'h0;
        else if (idleCnt_r != 16'hffff) idleCnt_r <= idleCnt_r + 16'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_estop_relays; estopOpen |=> !spindleRelay && !coolantRelay; endproperty
    a_estop_relays: assert property (p_estop_relays) else $error("relay on, loop open");
    property p_estop_flag; estopOpen |=> ledEstop && !hostStatusN; endproperty
    a_estop_flag: assert property (p_estop_flag) else $error("stop not flagged");
    property p_fault_flag; anyFault |=> ledFault && !hostStatusN; endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault not flagged");
    property p_brake_off; (estopOpen || anyFault) |=> !brakeRelay; endproperty
    a_brake_off: assert property (p_brake_off) else $error("brake open on stop");
    property p_brake_on; (!estopOpen && !anyFault)[*2] |=> brakeRelay; endproperty
    a_brake_on: assert property (p_brake_on) else $error("brake not open");
    property p_gate_steps; (!wdogBypass && !ledCpump)[*2] |=> stepOut == 4'h0; endproperty
    a_gate_steps: assert property (p_gate_steps) else $error("steps without pump");
    property p_cp_lost; (!wdogBypass)[*2] ##0 (idleCnt_r > CP_IDLE_MAX) |-> !ledCpump; endproperty
    a_cp_lost: assert property (p_cp_lost) else $error("pump valid while idle");
    property p_no_cred; lineCfg == 2'h3 |=> !currentReduce; endproperty
    a_no_cred: assert property (p_no_cred) else $error("reduction in mode 3");
    c_estop: cover property (estopOpen ##1 !hostStatusN);
    c_fault: cover property (axis4Status ##1 ledFault);
    c_cp: cover property ($rose(ledCpump));
endmodule
bind breakout_interlock interlock_sva i_sva (.clk_sys, .rst, .line16, .wdogBypass, .lineCfg,
    .estopOpen, .stageFault, .axis4Status, .stepOut, .currentReduce, .spindleRelay,
    .coolantRelay, .brakeRelay, .hostStatusN, .ledEstop, .ledFault, .ledCpump);

// File: testbench/host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk_sys, // system clock
    input wire logic cpRun, // pump running
    input wire logic [15:0] pwmPer, // pwm period in cycles
    input wire logic [15:0] pwmHi, // pwm high cycles
    output logic cpWave = 1'h0, // pump square wave
    output logic pwmWave = 1'h0 // pwm wave
);
    logic [15:0] cpCnt = 16'h0;
    logic [15:0] pwCnt = 16'h0;
    // a stopped pump holds its level, so the watchdog sees no edge at all
    always @(posedge clk_sys) begin
        cpCnt <= (cpCnt == 16'h31) ? 16'h0 : cpCnt + 16'h1;
        if (cpRun && cpCnt == 16'h31) cpWave <= !cpWave;
        pwCnt <= (pwCnt + 16'h1 >= pwmPer) ? 16'h0 : pwCnt + 16'h1;
        pwmWave <= (pwCnt < pwmHi);
    end
endmodule

// File: testbench/breakout_interlock_test.sv
`timescale 1ns/1ps
module breakout_interlock_test;
    logic clk_sys, rst, line1, line16, line17, line14, wdogBypass, estopOpen, axis4Status;
    logic cpRun, relayCmd, credCmd, cpWave, pwmWave, psel, penable, pwrite, rdy, errBit;
    logic pready, pslverr, irq, currentReduce, spindleRelay, coolantRelay, brakeRelay;
    logic hostStatusN, ledEstop, ledFault, ledCpump;
    logic [3:0] stepIn, dirIn, stepOut, dirOut;
    logic [1:0] lineCfg;
    logic [2:0] stageFault;
    logic [15:0] pwmPer, pwmHi;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [interlock_pkg::SPEED_W-1:0] speedOut;
    int errTotal = 0;
    int numChecks = 0;
    breakout_interlock i_dut (.clk_sys, .rst, .line1, .line16, .line17, .line14, .stepIn,
        .dirIn, .wdogBypass, .lineCfg, .estopOpen, .stageFault, .axis4Status, .stepOut, .dirOut,
        .currentReduce, .spindleRelay, .coolantRelay, .brakeRelay, .hostStatusN, .ledEstop,
        .ledFault, .ledCpump, .speedOut, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq);
    host_port_model i_host (.clk_sys, .cpRun, .pwmPer, .pwmHi, .cpWave, .pwmWave);
    // the jumper setting decides which host line carries which function
    always_comb begin
        line1 = (lineCfg == interlock_pkg::CFG_SHARED) ? pwmWave : relayCmd;
        line16 = (lineCfg == interlock_pkg::CFG_NO_WDOG) ? credCmd : cpWave;
        // shared and no-pwm modes carry reduction on line 17, the others carry pwm there
        line17 = (lineCfg[0] == 1'b0) ? credCmd : pwmWave;
    end
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    task printVerdict;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // waits, then samples at the falling edge where outputs are settled
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // answer taken at the very edge where pready is sampled high
        do begin
            @(posedge clk_sys);
            rdy = pready;
            rdat = prdata;
            errBit = pslverr;
            n++;
        end while (rdy !== 1'h1 && n < 16);
        psel <= 1'h0;
        penable <= 1'h0;
        if (rdy !== 1'h1) begin
            errTotal++;
            printVerdict;
        end
    endtask
    task t_watchdog;
        @(posedge clk_sys);
        stepIn <= 4'hf;
        dirIn <= 4'ha;
        cyc(5);
        chk(stepOut, 4'h0, "steps w/o pump");
        chk(dirOut, 4'ha, "dir passes");
        cpRun <= 1'h1;
        cyc(1000);
        chk(ledCpump, 1'h1, "pump valid");
        chk(stepOut, 4'hf, "steps with pump");
        cpRun <= 1'h0;
        cyc(interlock_pkg::CP_TIMEOUT_CYC + 100);
        chk(stepOut, 4'h0, "steps after loss");
        wdogBypass <= 1'h1;
        cyc(4);
        chk(stepOut, 4'hf, "steps in bypass");
        cpRun <= 1'h1;
        cyc(1000);
        wdogBypass <= 1'h0;
        $display("watchdog test done");
    endtask
    // duty table: 20 %, exactly 10 %, 5 %
    task t_pwm;
        int e;
        logic [15:0] hi [3] = '{16'h28, 16'h14, 16'ha};
        @(posedge clk_sys);
        line14 <= 1'h1;
        credCmd <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            pwmHi <= hi[i];
            cyc(1200);
            e = int'(hi[i]) * 1023 / int'(pwmPer);
            chk(spindleRelay, i < 2, "duty relay");
            chk(speedOut + 2 >= e && speedOut <= e + 2, 1'h1, "speed");
        end
        chk(currentReduce, 1'h1, "reduction line");
        chk(coolantRelay, 1'h1, "coolant");
        $display("pwm test done");
    endtask
    task t_cfg;
        logic [1:0] c [3] = '{2'h1, 2'h3, 2'h2};
        for (int i = 0; i < 3; i++) begin
            lineCfg <= c[i];
            wdogBypass <= (c[i] == 2'h1);
            relayCmd <= 1'h1;
            pwmHi <= 16'h64;
            cyc(1200);
            chk(spindleRelay, 1'h1, "relay line");
            chk(currentReduce, c[i] != 2'h3, "reduction");
            if (c[i] != 2'h2) chk(speedOut + 2 >= 511 && speedOut <= 513, 1'h1, "speed");
            relayCmd <= 1'h0;
            cyc(3);
            chk(spindleRelay, 1'h0, "relay off");
        end
        lineCfg <= 2'h0;
        wdogBypass <= 1'h0;
        pwmHi <= 16'h28;
        cyc(1200);
        $display("config test done");
    endtask
    task t_stop;
        apb(1'h1, interlock_pkg::REG_IRQ_EN, 32'h3);
        estopOpen <= 1'h1;
        cyc(3);
        chk({spindleRelay, coolantRelay}, 2'h0, "relays");
        chk({ledEstop, hostStatusN, brakeRelay}, 3'h4, "stop flags");
        chk(irq, 1'h1, "irq set");
        apb(1'h0, interlock_pkg::REG_IRQ_STAT, 32'h0);
        chk(rdat[0], 1'h1, "stop event");
        apb(1'h1, interlock_pkg::REG_IRQ_CLR, 32'h1);
        cyc(2);
        chk(irq, 1'h0, "irq cleared");
        estopOpen <= 1'h0;
        cyc(3);
        chk({coolantRelay, hostStatusN, brakeRelay}, 3'h7, "released");
        // software coolant-off bit in the control register
        apb(1'h1, interlock_pkg::REG_CTRL, 32'h2);
        cyc(3);
        chk(coolantRelay, 1'h0, "coolant held off");
        apb(1'h0, interlock_pkg::REG_CTRL, 32'h0);
        chk(rdat, 32'h2, "ctrl readback");
        apb(1'h1, interlock_pkg::REG_CTRL, 32'h0);
        cyc(3);
        chk(coolantRelay, 1'h1, "coolant back");
        axis4Status <= 1'h1;
        cyc(3);
        chk({ledFault, hostStatusN, brakeRelay}, 3'h4, "ext fault");
        chk(irq, 1'h1, "fault irq");
        apb(1'h1, interlock_pkg::REG_IRQ_EN, 32'h0);
        cyc(2);
        chk(irq, 1'h0, "irq masked");
        axis4Status <= 1'h0;
        stageFault <= 3'h4;
        cyc(3);
        chk({ledFault, hostStatusN}, 2'h2, "stage fault");
        apb(1'h0, 8'h40, 32'h0);
        chk(errBit, 1'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        $display("stop test done");
    endtask
    initial begin
        {rst, line14, wdogBypass, estopOpen, axis4Status, cpRun, relayCmd, credCmd} = 8'h80;
        {psel, penable, pwrite, stepIn, dirIn, lineCfg, stageFault} = 16'h0;
        {paddr, pwdata, pwmPer, pwmHi} = {40'h0, 16'hc8, 16'h0};
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        apb(1'h0, interlock_pkg::REG_IRQ_EN, 32'h0);
        chk(rdat, {28'h0, interlock_pkg::IRQ_EN_RST}, "enable reset");
        t_watchdog;
        t_pwm;
        t_cfg;
        t_stop;
        printVerdict;
    end
endmodule
